// >>> hw/cpsc_defs.svh
// Purpose: Addresses, bit positions and reset values of the port block
// Assumes: Big-endian bit numbers count from the word's most significant bit
// Notes:   Included by the table and top modules, the host model and the bench
`ifndef CPSC_DEFS_SVH
`define CPSC_DEFS_SVH
`define CPSC_PPF_BASE    48'hffff_f2f0_00c8
`define CPSC_STB_BASE    48'hffff_f2f0_0300
`define CPSC_OFS_OUT     12'h000
`define CPSC_OFS_IN      12'h004
`define CPSC_OFS_SUM     12'h000
`define CPSC_OFS_CAP0    12'h100
`define CPSC_OFS_CAP1    12'h104
`define CPSC_OFS_CAP2    12'h108
`define CPSC_OFS_CAP3    12'h10c
`define CPSC_DOC_PORT0   31
`define CPSC_DOC_SUM0    0
`define CPSC_DOC_PRESENT 0
`define CPSC_DOC_READOUT 4
`define CPSC_DOC_ONOFF   5
`define CPSC_DOC_POL     6
`define CPSC_DOC_MIN     8
`define CPSC_DOC_MAX     20
`define CPSC_CAP_MIN     12'h000
`define CPSC_CAP_MAX     12'hfff
`define CPSC_OUT_RST     4'h0
`endif

// >>> hw/cpsc_pkg.sv
// Purpose: Types and bit helpers of the port block
// Assumes: Big-endian bit 0 is the most significant bit of a 32-bit word
// Notes:   None
package cpsc_pkg;
    typedef logic [47:0] cpsc_addr_t;
    typedef logic [31:0] cpsc_word_t;
    typedef enum logic {CPSC_RSP_IDLE, CPSC_RSP_ANSWER} cpsc_rsp_e;

    // Big-endian bit number to vector index
    function automatic int cpsc_hw_bit(input int doc);
        return 31 - doc;
    endfunction

    function automatic logic cpsc_at(input cpsc_addr_t a,
                                     input cpsc_addr_t base,
                                     input logic [11:0] ofs);
        return a == base + {36'h0, ofs};
    endfunction
endpackage

// >>> hw/cpsc_cap_if.sv
// Purpose: Carries a capability lookup between top and table
// Assumes: Same clock, purely combinational lookup
// Notes:   None
`timescale 1ns/1ps
interface cpsc_cap_if;
    logic              sum_sel;
    logic [1:0]        sel;
    cpsc_pkg::cpsc_word_t word;
    modport table_end (input sum_sel, input sel, output word);
    modport user_end  (output sum_sel, output sel, input word);
endinterface

// >>> hw/cpsc_sync.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module cpsc_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// >>> hw/cpsc_cap_table.sv
// Purpose: Read-only strobe capability words
// Assumes: Every present strobe shares one field layout
// Notes:   Absent strobes read as all zero
`timescale 1ns/1ps
`include "cpsc_defs.svh"
module cpsc_cap_table import cpsc_pkg::*; #(
    parameter logic [3:0]  PRESENT = 4'hf,
    parameter logic [11:0] CAP_MIN = `CPSC_CAP_MIN,
    parameter logic [11:0] CAP_MAX = `CPSC_CAP_MAX
) (
    cpsc_cap_if.table_end cap
);
    always_comb
    begin
        cap.word = '0;
        if (cap.sum_sel)
        begin
            for (int i = 0; i < 4; i++)
                cap.word[cpsc_hw_bit(`CPSC_DOC_SUM0 + i)] = PRESENT[i];
        end
        else if (PRESENT[cap.sel])
        begin
            cap.word[cpsc_hw_bit(`CPSC_DOC_PRESENT)] = 1'b1;
            cap.word[cpsc_hw_bit(`CPSC_DOC_READOUT)] = 1'b1;
            cap.word[cpsc_hw_bit(`CPSC_DOC_ONOFF)]   = 1'b1;
            cap.word[cpsc_hw_bit(`CPSC_DOC_POL)]     = 1'b1;
            cap.word[cpsc_hw_bit(`CPSC_DOC_MIN) -: 12] = CAP_MIN;
            cap.word[cpsc_hw_bit(`CPSC_DOC_MAX) -: 12] = CAP_MAX;
        end
    end
endmodule

// >>> hw/cpsc_top.sv
// Purpose: Output port drive, input port levels, strobe capabilities
// Assumes: Host accesses arrive as one-cycle quadlet requests on clk
// Notes:   Input pins pass a two-flop synchroniser, output pins one flop; answers follow in one cycle
`timescale 1ns/1ps
`include "cpsc_defs.svh"

// What this block does
// - Big-endian bit zero is word MSB
// - Port registers decoded at port base plus offset
// - Output register doc bits 31..28 drive ports 0..3
// - Input register doc bits 31..28 show pin levels
// - Strobe registers decoded at strobe base plus offset
// - Summary returns one presence bit per strobe
// - Capability flags present, readable, switchable, polarity
// - Capability range minimum zero, maximum 4095
// - Strobes 1..3 copy strobe 0 capabilities
// - Strobe reaches port only when port selects it
module cpsc_top import cpsc_pkg::*; #(
    parameter logic [3:0] STROBE_PRESENT = 4'hf
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire cpsc_addr_t req_addr,
    input  wire cpsc_word_t req_wdata,
    output logic            rsp_valid,
    output cpsc_word_t      rsp_rdata,
    output logic            rsp_err,
    input  wire logic [3:0] port_in_pin,
    output logic      [3:0] port_out_pin,
    input  wire logic [3:0] strobe_level,
    input  wire logic [3:0] port_is_strobe
);
    ////////////////////////////////////////////////////////////////////////
    // Port field packing
    ////////////////////////////////////////////////////////////////////////
    function automatic cpsc_word_t place_ports(input logic [3:0] p);
        cpsc_word_t w;
        w = '0;
        for (int i = 0; i < 4; i++)
            w[cpsc_hw_bit(`CPSC_DOC_PORT0 - i)] = p[i];
        return w;
    endfunction

    function automatic logic [3:0] take_ports(input cpsc_word_t w);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 4; i++)
            p[i] = w[cpsc_hw_bit(`CPSC_DOC_PORT0 - i)];
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser and capability table
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] in_level;
    cpsc_cap_if cap ();

    cpsc_sync #(.W(4)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (port_in_pin),
        .q   (in_level)
    );

    cpsc_cap_table #(
        .PRESENT (STROBE_PRESENT),
        .CAP_MIN (`CPSC_CAP_MIN),
        .CAP_MAX (`CPSC_CAP_MAX)
    ) u_caps (
        .cap (cap.table_end)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    ////////////////////////////////////////////////////////////////////////
    logic       hit_out;
    logic       hit_in;
    logic       hit_sum;
    logic       hit_cap;
    logic [1:0] cap_idx;

    always_comb
    begin
        hit_out = cpsc_at(req_addr, `CPSC_PPF_BASE, `CPSC_OFS_OUT);
        hit_in  = cpsc_at(req_addr, `CPSC_PPF_BASE, `CPSC_OFS_IN);
        hit_sum = cpsc_at(req_addr, `CPSC_STB_BASE, `CPSC_OFS_SUM);
        hit_cap = 1'b1;
        cap_idx = 2'h0;
        if (cpsc_at(req_addr, `CPSC_STB_BASE, `CPSC_OFS_CAP1))
            cap_idx = 2'h1;
        else if (cpsc_at(req_addr, `CPSC_STB_BASE, `CPSC_OFS_CAP2))
            cap_idx = 2'h2;
        else if (cpsc_at(req_addr, `CPSC_STB_BASE, `CPSC_OFS_CAP3))
            cap_idx = 2'h3;
        else if (!cpsc_at(req_addr, `CPSC_STB_BASE, `CPSC_OFS_CAP0))
            hit_cap = 1'b0;
    end

    assign cap.sum_sel = hit_sum;
    assign cap.sel     = cap_idx;

    ////////////////////////////////////////////////////////////////////////
    // Register file and answer
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] drive_r;
    logic [3:0] drive_nxt;
    cpsc_rsp_e  rsp_state_r;
    cpsc_rsp_e  rsp_state_nxt;
    cpsc_word_t rdata_r;
    cpsc_word_t rdata_nxt;
    logic       err_r;
    logic       err_nxt;

    always_comb
    begin
        drive_nxt     = drive_r;
        rdata_nxt     = '0;
        err_nxt       = 1'b0;
        rsp_state_nxt = req_valid ? CPSC_RSP_ANSWER : CPSC_RSP_IDLE;
        if (req_valid)
        begin
            if (hit_out)
            begin
                if (req_write)
                    drive_nxt = take_ports(req_wdata);
                else
                    rdata_nxt = place_ports(drive_r);
            end
            else if (hit_in)
            begin
                if (!req_write)
                    rdata_nxt = place_ports(in_level);
            end
            else if (hit_sum || hit_cap)
            begin
                if (!req_write)
                    rdata_nxt = cap.word;
            end
            else
            begin
                err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            drive_r     <= `CPSC_OUT_RST;
            rsp_state_r <= CPSC_RSP_IDLE;
            rdata_r     <= '0;
            err_r       <= 1'b0;
        end
        else
        begin
            drive_r     <= drive_nxt;
            rsp_state_r <= rsp_state_nxt;
            rdata_r     <= rdata_nxt;
            err_r       <= err_nxt;
        end
    end

    assign rsp_valid = (rsp_state_r == CPSC_RSP_ANSWER);
    assign rsp_rdata = rdata_r;
    assign rsp_err   = err_r;

    ////////////////////////////////////////////////////////////////////////
    // Output pins
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] pin_r;
    logic [3:0] pin_nxt;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_nxt[i] = port_is_strobe[i] ? strobe_level[i] : drive_r[i];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pin_r <= `CPSC_OUT_RST;
        else
            pin_r <= pin_nxt;
    end

    assign port_out_pin = pin_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    cpsc_word_t cap_expect;
    cpsc_word_t sum_expect;

    always_comb
    begin
        cap_expect = '0;
        cap_expect[31]    = 1'b1;
        cap_expect[27:25] = 3'h7;
        cap_expect[23:12] = `CPSC_CAP_MIN;
        cap_expect[11:0]  = `CPSC_CAP_MAX;
        sum_expect        = {STROBE_PRESENT[0], STROBE_PRESENT[1],
                             STROBE_PRESENT[2], STROBE_PRESENT[3], 28'h0};
    end

    // Last value written to the output register, for readback checks
    logic [3:0] out_wr_r;
    logic [3:0] out_wr_nxt;

    always_comb
    begin
        out_wr_nxt = out_wr_r;
        if (req_valid && req_write && hit_out)
            out_wr_nxt = req_wdata[3:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out_wr_r <= `CPSC_OUT_RST;
        else
            out_wr_r <= out_wr_nxt;
    end

    sequence s_read(logic hit);
        req_valid && !req_write && hit;
    endsequence

    sequence s_write(logic hit);
        req_valid && req_write && hit;
    endsequence

    a_rsp_one_cycle: assert property (
        req_valid |=> rsp_valid && $past(req_valid))
        else $error("Answer not one cycle after request");

    a_rsp_no_spurious: assert property (
        !req_valid |=> !rsp_valid)
        else $error("Answer without request");

    a_out_write_pin: assert property (
        s_write(hit_out) ##1 !port_is_strobe[0] && !(req_valid && hit_out)
        |=> port_out_pin[0] == $past(req_wdata[0], 2))
        else $error("Port 0 pin does not follow output write");

    a_out_readback: assert property (
        s_read(hit_out) |=> rsp_rdata == {28'h0, $past(out_wr_r)} && !rsp_err)
        else $error("Output register readback wrong");

    a_in_level_read: assert property (
        $stable(port_in_pin) [*3] ##0 s_read(hit_in)
        |=> rsp_rdata == place_ports($past(port_in_pin)) && !rsp_err)
        else $error("Input register does not show pin level");

    a_sum_value: assert property (
        s_read(hit_sum) |=> rsp_rdata == sum_expect && !rsp_err)
        else $error("Strobe summary value wrong");

    a_cap_value: assert property (
        s_read(hit_cap) && STROBE_PRESENT[cap_idx]
        |=> rsp_rdata == cap_expect && !rsp_err)
        else $error("Strobe capability value wrong");

    a_cap_alias: assert property (
        s_read(cpsc_at(req_addr, `CPSC_STB_BASE, `CPSC_OFS_CAP3)) && STROBE_PRESENT[3]
        |=> rsp_rdata[11:0] == 12'hfff && rsp_rdata[23:12] == 12'h000)
        else $error("Strobe 3 range differs");

    a_ro_write_kept: assert property (
        req_valid && req_write && !hit_out |=> $stable(drive_r) && rsp_rdata == '0)
        else $error("Write to read-only register had effect");

    a_unmapped_err: assert property (
        req_valid && !hit_out && !hit_in && !hit_sum && !hit_cap
        |=> rsp_err && rsp_rdata == '0)
        else $error("Unmapped address not flagged");

    a_strobe_route: assert property (
        port_is_strobe[0] |=> port_out_pin[0] == $past(strobe_level[0]))
        else $error("Strobe not routed to port 0");

    a_drive_route: assert property (
        !port_is_strobe[2] |=> port_out_pin[2] == $past(drive_r[2]))
        else $error("Port 2 shows strobe while not selected");

    a_strobe_port2: assert property (
        port_is_strobe[2] |=> port_out_pin[2] == $past(strobe_level[2]))
        else $error("Strobe not routed to port 2");

    a_write_rdata_zero: assert property (
        s_write(1'b1) |=> rsp_rdata == '0)
        else $error("Write answer carries data");

    a_ro_write_no_err: assert property (
        s_write(hit_in || hit_sum || hit_cap) |=> !rsp_err)
        else $error("Write to read-only register flagged as error");
endmodule

// >>> verif/cpsc_host_model.sv
// Purpose: Host that reads and writes the port block registers
// Assumes: One request at a time, launched at a falling edge
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
`include "cpsc_defs.svh"
module cpsc_host_model import cpsc_pkg::*; (
    input  wire logic       clk,
    output logic            req_valid,
    output logic            req_write,
    output cpsc_addr_t      req_addr,
    output cpsc_word_t      req_wdata,
    input  wire logic       rsp_valid,
    input  wire cpsc_word_t rsp_rdata,
    input  wire logic       rsp_err
);
    logic       seen;
    logic       err;
    cpsc_word_t rdata;

    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr  = '0;
        req_wdata = '0;
    end

    // Held across one rising edge, answer taken at the following falling edge
    task automatic access(input logic wr, input cpsc_addr_t a, input cpsc_word_t d);
        @(negedge clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        @(negedge clk);
        seen      = rsp_valid;
        err       = rsp_err;
        rdata     = rsp_rdata;
        req_valid = 1'b0;
        req_write = ~wr;
        req_addr  = ~a;
        req_wdata = ~d;
    endtask

    task automatic ppf(input logic wr, input logic [11:0] ofs, input cpsc_word_t d);
        access(wr, `CPSC_PPF_BASE + {36'h0, ofs}, d);
    endtask

    task automatic stb(input logic wr, input logic [11:0] ofs, input cpsc_word_t d);
        access(wr, `CPSC_STB_BASE + {36'h0, ofs}, d);
    endtask

    // A cleared capability bit means the feature is missing
    function automatic logic supported(input cpsc_word_t w, input int doc_bit);
        return w[31 - doc_bit] == 1'b1;
    endfunction
endmodule

// >>> verif/cpsc_top_tb.sv
// Purpose: Self-checking bench of the port block
// Assumes: The host model makes every register access
// Notes:   Pin inputs change at falling edges
`timescale 1ns/1ps
`include "cpsc_defs.svh"
module cpsc_top_tb import cpsc_pkg::*;;
    logic       clk;
    logic       rst;
    logic [3:0] port_in_pin;
    logic [3:0] port_out_pin;
    logic [3:0] strobe_level;
    logic [3:0] port_is_strobe;
    logic       req_valid;
    logic       req_write;
    cpsc_addr_t req_addr;
    cpsc_word_t req_wdata;
    logic       rsp_valid;
    cpsc_word_t rsp_rdata;
    logic       rsp_err;
    int         num_errors = 0;
    int         checked = 0;
    int         cycles = 0;

    cpsc_top cpsc_top_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .port_in_pin(port_in_pin),
        .port_out_pin(port_out_pin), .strobe_level(strobe_level),
        .port_is_strobe(port_is_strobe));

    cpsc_host_model cpsc_host_model_i (.clk(clk), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check_word(input string name, input cpsc_word_t exp, input cpsc_word_t got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic expect_rsp(input string name, input cpsc_word_t exp, input logic exp_err);
        check_flag({name, " valid"}, 1'b1, cpsc_host_model_i.seen);
        check_flag({name, " err"}, exp_err, cpsc_host_model_i.err);
        check_word(name, exp, cpsc_host_model_i.rdata);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check_word("reset pins", 32'h0, {28'h0, port_out_pin});
        cpsc_host_model_i.ppf(1'b0, `CPSC_OFS_OUT, 32'h0);
        expect_rsp("reset out reg", 32'h0, 1'b0);
    endtask

    task automatic t_output;
        for (int i = 0; i < 4; i++)
        begin
            cpsc_host_model_i.ppf(1'b1, `CPSC_OFS_OUT, 32'hffff_fff0 | (32'h1 << i));
            expect_rsp("out write", 32'h0, 1'b0);
            @(negedge clk);
            check_word("out pins", 32'h1 << i, {28'h0, port_out_pin});
            cpsc_host_model_i.ppf(1'b0, `CPSC_OFS_OUT, 32'h0);
            expect_rsp("out read", 32'h1 << i, 1'b0);
        end
    endtask

    task automatic t_input;
        logic [3:0] pat [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'ha};
        foreach (pat[k])
        begin
            port_in_pin = pat[k];
            repeat (3) @(negedge clk);
            cpsc_host_model_i.ppf(1'b0, `CPSC_OFS_IN, 32'h0);
            expect_rsp("in read", {28'h0, pat[k]}, 1'b0);
        end
        cpsc_host_model_i.ppf(1'b1, `CPSC_OFS_IN, 32'hffff_ffff);
        expect_rsp("in write", 32'h0, 1'b0);
        cpsc_host_model_i.ppf(1'b0, `CPSC_OFS_IN, 32'h0);
        expect_rsp("in kept", 32'ha, 1'b0);
    endtask

    task automatic t_caps;
        cpsc_host_model_i.stb(1'b0, `CPSC_OFS_SUM, 32'h0);
        expect_rsp("summary", 32'hf000_0000, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            cpsc_host_model_i.stb(1'b1, `CPSC_OFS_CAP0 + 12'(4 * i), 32'h0);
            expect_rsp("cap write", 32'h0, 1'b0);
            cpsc_host_model_i.stb(1'b0, `CPSC_OFS_CAP0 + 12'(4 * i), 32'h0);
            expect_rsp("cap read", 32'h8e00_0fff, 1'b0);
            check_flag("cap pol", 1'b1,
                cpsc_host_model_i.supported(cpsc_host_model_i.rdata, 6));
        end
    endtask

    task automatic t_strobe;
        cpsc_host_model_i.ppf(1'b1, `CPSC_OFS_OUT, 32'h3);
        port_is_strobe = 4'b0101;
        strobe_level   = 4'b1110;
        @(negedge clk);
        check_word("strobe mix", 32'h6, {28'h0, port_out_pin});
        strobe_level = 4'b0001;
        @(negedge clk);
        check_word("strobe follow", 32'h3, {28'h0, port_out_pin});
        port_is_strobe = 4'b0000;
        strobe_level   = 4'b1111;
        @(negedge clk);
        check_word("strobe off", 32'h3, {28'h0, port_out_pin});
    endtask

    task automatic t_unmapped;
        cpsc_host_model_i.ppf(1'b0, 12'h008, 32'h0);
        expect_rsp("gap read", 32'h0, 1'b1);
        cpsc_host_model_i.stb(1'b0, 12'h110, 32'h0);
        expect_rsp("strobe gap", 32'h0, 1'b1);
        cpsc_host_model_i.ppf(1'b1, 12'h001, 32'hf);
        expect_rsp("unaligned", 32'h0, 1'b1);
        cpsc_host_model_i.ppf(1'b0, `CPSC_OFS_OUT, 32'h0);
        expect_rsp("out kept", 32'h3, 1'b0);
    endtask

    task automatic t_reset_mid;
        rst = 1'b1;
        @(negedge clk);
        @(negedge clk);
        check_word("mid reset pins", 32'h0, {28'h0, port_out_pin});
        rst = 1'b0;
        cpsc_host_model_i.ppf(1'b0, `CPSC_OFS_OUT, 32'h0);
        expect_rsp("mid reset out reg", 32'h0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst            = 1'b1;
        port_in_pin    = 4'h0;
        strobe_level   = 4'h0;
        port_is_strobe = 4'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_output();
        t_input();
        t_caps();
        t_strobe();
        t_unmapped();
        t_reset_mid();
        finish_test();
    end
endmodule
